// ### hdl/fsd_consts.svh
// Constants for the flash status and deep sleep block
`ifndef FSD_CONSTS_SVH
`define FSD_CONSTS_SVH

// ==========================================
// Opcodes
`define FSD_OP_SLEEP 8'hb9
`define FSD_OP_WAKE 8'hab
`define FSD_OP_STATUS 8'hd7

// ==========================================
// Status byte two field positions
`define FSD_S2_READY 7
`define FSD_S2_SPARE_HI 6
`define FSD_S2_FAIL 5
`define FSD_S2_SPARE_LO 4
`define FSD_S2_LOCKDOWN 3
`define FSD_S2_BUF_TWO 2
`define FSD_S2_BUF_ONE 1
`define FSD_S2_ERASE 0

// ==========================================
// Status byte one field positions
`define FSD_S1_READY 7
`define FSD_S1_COMPARE 6
`define FSD_S1_CAP_HI 5
`define FSD_S1_CAP_LO 2
`define FSD_S1_PROTECT 1
`define FSD_S1_GEOMETRY 0

// ==========================================
// Reset values and fixed codes
`define FSD_SPARE_VAL 1'b0
`define FSD_S2_RST 8'h80
// Capacity code value is arbitrary
`define FSD_CAP_CODE 4'h5
`define FSD_GEOM_528 1'b0
`define FSD_GEOM_512 1'b1
`define FSD_PIN_RST 3'h7

// ==========================================
// Timing
`define FSD_CLK_MHZ 125
`define FSD_SLEEP_ENTRY_NS 1000
`define FSD_SLEEP_EXIT_NS 1000

`endif

// ### hdl/fsd_pkg.sv
// Types for the flash status and deep sleep block
package fsd_pkg;

  // ==========================================
  // Power state
  typedef enum logic [2:0] {
    FSD_STANDBY,
    FSD_ENTERING,
    FSD_ASLEEP,
    FSD_WAKING
  } fsd_pwr_t;

  typedef logic [7:0] fsd_byte_t;

endpackage

// ### hdl/fsd_sync.sv
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module fsd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= RST;
      q_o <= RST;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

// ### hdl/fsd_top.sv
// Status byte two, status read and deep sleep command interpreter
`timescale 1ns/1ps
`include "fsd_consts.svh"

// Notes on behaviour
// [R1] Host keeps reading status until the ready bit rises from 0 to 1.
// [R2] Bit 5 reads 1 after a failed erase or program, 0 after success.
// [R3] An aborted erase or program leaves the failure bit clear.
// [R4] The failure bit is refreshed at the end of every erase and program.
// [R5] Bits 6 and 4 of status byte two always read 0.
// [R6] Bit 3 reads 1 while sector lockdown is still usable, else 0.
// [R7] Bit 2 shows buffer-two program suspend; buffer-two writes are then ignored.
// [R8] Bit 1 shows buffer-one program suspend; buffer-one writes are then ignored.
// [R9] Bit 0 reads 1 while any page, block or sector erase is suspended.
// [R10] Compare bit holds latest page-versus-buffer result, 1 on any mismatch.
// [R11] A fixed four-bit capacity code appears in status byte one.
// [R12] Protect bit shows sector protection, enabled by command or pin.
// [R13] Geometry bit tells 512-byte from 528-byte page configuration.
// [R14] Standby whenever deselected and no internal operation runs.
// [R15] Asleep, every command except resume is ignored, status read too.
// [R16] Opcode B9h then deselect enters deep sleep after a bounded delay.
// [R17] Short or unaligned sleep command aborts and stays in standby.
// [R18] After reset the block starts in standby.
// [R19] Sleep command ignored while a self-timed program or erase runs.
// [R20] Opcode ABh then deselect returns to standby after a bounded delay.
// [R21] Short or unaligned resume command aborts and stays asleep.
// [R22] Host waits for standby after resume before ordinary commands.
// [R23] Opcode D7h streams both status bytes, repeating while selected.
// [R24] Geometry bit reads 0 for 528 bytes and 1 for 512 bytes.
// [R25] Entry and exit delays are cycle counts; link activity then ignored.
module fsd_top #(
  parameter int ENTRY_NS = `FSD_SLEEP_ENTRY_NS,
  parameter int EXIT_NS = `FSD_SLEEP_EXIT_NS
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Serial link pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // Internal operation state
  input wire logic op_busy_i,
  input wire logic op_done_i,
  input wire logic op_fail_i,
  input wire logic op_abort_i,
  input wire logic cmp_done_i,
  input wire logic cmp_mismatch_i,
  input wire logic lockdown_allowed_i,
  input wire logic buf_two_prog_suspended_i,
  input wire logic buf_one_prog_suspended_i,
  input wire logic erase_suspended_i,
  input wire logic protect_i,
  input wire logic page_512_i,
  // Status and power outputs
  output fsd_pkg::fsd_byte_t status_byte_two_o,
  output logic standby_o,
  output logic deep_sleep_o,
  // Commands and buffer write guards forwarded to the rest of the device
  output logic cmd_valid_o,
  output fsd_pkg::fsd_byte_t cmd_opcode_o,
  output logic buf_one_guard_o,
  output logic buf_two_guard_o
);
  import fsd_pkg::*;

  // ==========================================
  // Delay counts
  localparam int ENTRY_CYC_RAW = (ENTRY_NS * `FSD_CLK_MHZ) / 1000;
  localparam int EXIT_CYC_RAW = (EXIT_NS * `FSD_CLK_MHZ) / 1000;
  localparam int ENTRY_CYC = (ENTRY_CYC_RAW < 1) ? 1 : ENTRY_CYC_RAW;
  localparam int EXIT_CYC = (EXIT_CYC_RAW < 1) ? 1 : EXIT_CYC_RAW;
  localparam logic [15:0] ENTRY_LAST = 16'(ENTRY_CYC - 1);
  localparam logic [15:0] EXIT_LAST = 16'(EXIT_CYC - 1);

  // ==========================================
  // Pin synchronisation
  logic [2:0] pins_s;
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic cs_n_d;
  logic sck_d;

  fsd_sync #(
    .W(3),
    .RST(`FSD_PIN_RST)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .d_i({cs_n_i, sck_i, si_i}),
    .q_o(pins_s)
  );

  assign cs_n_s = pins_s[2];
  assign sck_s = pins_s[1];
  assign si_s = pins_s[0];

  // Previous synchronised levels for edge detection
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_n_d <= 1'b1;
      sck_d <= 1'b1;
    end else begin
      cs_n_d <= cs_n_s;
      sck_d <= sck_s;
    end
  end

  logic sel_start;
  logic sel_end;
  logic sck_rise;
  logic sck_fall;

  assign sel_start = cs_n_d & ~cs_n_s;
  assign sel_end = ~cs_n_d & cs_n_s;
  assign sck_rise = ~cs_n_s & ~sck_d & sck_s;
  assign sck_fall = ~cs_n_s & sck_d & ~sck_s;

  // ==========================================
  // Opcode shifter
  logic [6:0] shreg;
  logic [2:0] bit_cnt;
  logic got_op;
  fsd_byte_t opcode;

  // Later bytes of a frame never replace the first opcode
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shreg <= 7'h00;
      bit_cnt <= 3'h0;
      got_op <= 1'b0;
      opcode <= 8'h00;
    end else if (sel_start) begin
      bit_cnt <= 3'h0;
      got_op <= 1'b0;
    end else if (sck_rise) begin
      shreg <= {shreg[5:0], si_s};
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7 && !got_op) begin
        opcode <= {shreg, si_s};
        got_op <= 1'b1;
      end
    end
  end

  // Whole opcode in and deselected on a byte boundary
  logic framed;
  assign framed = got_op & (bit_cnt == 3'h0);

  // ==========================================
  // Power state machine
  fsd_pwr_t pwr;
  logic [15:0] dly_cnt;
  logic awake;

  assign awake = (pwr == FSD_STANDBY);

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr <= FSD_STANDBY; // R18
      dly_cnt <= 16'h0000;
    end else begin
      unique case (pwr)
        FSD_STANDBY: begin
          dly_cnt <= 16'h0000;
          if (sel_end && framed && opcode == `FSD_OP_SLEEP && !op_busy_i) begin // R16 R17 R19
            pwr <= FSD_ENTERING;
          end
        end
        FSD_ENTERING: begin
          dly_cnt <= dly_cnt + 16'h0001; // R25
          if (dly_cnt == ENTRY_LAST) begin // R16
            pwr <= FSD_ASLEEP;
          end
        end
        FSD_ASLEEP: begin
          dly_cnt <= 16'h0000;
          if (sel_end && framed && opcode == `FSD_OP_WAKE) begin // R20 R21
            pwr <= FSD_WAKING;
          end
        end
        FSD_WAKING: begin
          dly_cnt <= dly_cnt + 16'h0001; // R25
          if (dly_cnt == EXIT_LAST) begin // R20 R22
            pwr <= FSD_STANDBY;
          end
        end
        // Unused codes of the state register fall back to standby
        default: begin
          pwr <= FSD_STANDBY;
          dly_cnt <= 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      standby_o <= 1'b1;
    end else begin
      standby_o <= awake & cs_n_s & ~op_busy_i; // R14
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      deep_sleep_o <= 1'b0;
    end else begin
      deep_sleep_o <= (pwr == FSD_ASLEEP); // R16
    end
  end

  // ==========================================
  // Status flags
  logic fail_flag;
  logic cmp_flag;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fail_flag <= 1'b0;
    end else if (op_done_i) begin
      fail_flag <= op_fail_i & ~op_abort_i; // R2 R3 R4
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmp_flag <= 1'b0;
    end else if (cmp_done_i) begin
      cmp_flag <= cmp_mismatch_i; // R10
    end
  end

  fsd_byte_t next_byte_two;
  fsd_byte_t byte_one;

  always_comb begin
    next_byte_two = 8'h00;
    next_byte_two[`FSD_S2_READY] = ~op_busy_i; // R1
    next_byte_two[`FSD_S2_SPARE_HI] = `FSD_SPARE_VAL; // R5
    next_byte_two[`FSD_S2_FAIL] = fail_flag; // R2
    next_byte_two[`FSD_S2_SPARE_LO] = `FSD_SPARE_VAL; // R5
    next_byte_two[`FSD_S2_LOCKDOWN] = lockdown_allowed_i; // R6
    next_byte_two[`FSD_S2_BUF_TWO] = buf_two_prog_suspended_i; // R7
    next_byte_two[`FSD_S2_BUF_ONE] = buf_one_prog_suspended_i; // R8
    next_byte_two[`FSD_S2_ERASE] = erase_suspended_i; // R9
  end

  always_comb begin
    byte_one = 8'h00;
    byte_one[`FSD_S1_READY] = ~op_busy_i;
    byte_one[`FSD_S1_COMPARE] = cmp_flag; // R10
    byte_one[`FSD_S1_CAP_HI:`FSD_S1_CAP_LO] = `FSD_CAP_CODE; // R11
    byte_one[`FSD_S1_PROTECT] = protect_i; // R12
    byte_one[`FSD_S1_GEOMETRY] = page_512_i ? `FSD_GEOM_512 : `FSD_GEOM_528; // R13 R24
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_byte_two_o <= `FSD_S2_RST;
    end else begin
      status_byte_two_o <= next_byte_two;
    end
  end

  // Buffer logic drops writes while its program is suspended
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      buf_one_guard_o <= 1'b0;
      buf_two_guard_o <= 1'b0;
    end else begin
      buf_one_guard_o <= buf_one_prog_suspended_i; // R8
      buf_two_guard_o <= buf_two_prog_suspended_i; // R7
    end
  end

  // ==========================================
  // Status read stream
  logic rd_act;
  logic [3:0] rd_idx;
  fsd_byte_t cur_byte;
  fsd_byte_t rd_byte;

  // Byte one first, then byte two, as the bit index runs
  assign cur_byte = rd_idx[3] ? next_byte_two : byte_one;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_act <= 1'b0;
    end else if (cs_n_s) begin
      rd_act <= 1'b0;
    end else if (sck_rise && bit_cnt == 3'h7 && !got_op) begin
      rd_act <= awake & ({shreg, si_s} == `FSD_OP_STATUS); // R15 R23
    end
  end

  // Each byte is frozen at its first bit so it never mixes two states
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_idx <= 4'h0;
      rd_byte <= 8'h00;
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
    end else if (!rd_act || cs_n_s) begin
      rd_idx <= 4'h0;
      so_oe_o <= 1'b0;
      so_o <= 1'b0;
    end else if (sck_fall) begin
      so_oe_o <= 1'b1;
      rd_idx <= rd_idx + 4'h1; // R23
      if (rd_idx[2:0] == 3'h0) begin
        rd_byte <= cur_byte;
        so_o <= cur_byte[7]; // R23
      end else begin
        so_o <= rd_byte[3'h7 - rd_idx[2:0]]; // R23
      end
    end
  end

  // ==========================================
  // Command forwarding
  logic own_op;
  assign own_op = (opcode == `FSD_OP_SLEEP) | (opcode == `FSD_OP_WAKE) | (opcode == `FSD_OP_STATUS);

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_valid_o <= 1'b0;
    end else begin
      cmd_valid_o <= sel_end & got_op & awake & ~own_op; // R15 R25
    end
  end

  // Opcode holds after the pulse so the far side may take it late
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_opcode_o <= 8'h00;
    end else if (sel_end && got_op && awake) begin
      cmd_opcode_o <= opcode; // R15
    end
  end

endmodule

// ### dv/fsd_top_properties.sv
// Concurrent checks on the status and deep sleep block ports
`timescale 1ns/1ps
module fsd_top_properties #(
  parameter int ENTRY_NS = 1000,
  parameter int EXIT_NS = 1000
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Inputs watched
  input wire logic op_busy_i,
  input wire logic op_done_i,
  input wire logic op_fail_i,
  input wire logic op_abort_i,
  input wire logic lockdown_allowed_i,
  input wire logic buf_two_prog_suspended_i,
  input wire logic buf_one_prog_suspended_i,
  input wire logic erase_suspended_i,
  // Outputs watched
  input wire logic so_oe_o,
  input wire fsd_pkg::fsd_byte_t status_byte_two_o,
  input wire logic standby_o,
  input wire logic deep_sleep_o,
  input wire logic cmd_valid_o,
  input wire logic buf_one_guard_o,
  input wire logic buf_two_guard_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  a_spare_bits_zero: assert property (!status_byte_two_o[6] && !status_byte_two_o[4])
    else $error("spare status bits not zero");
  a_flags_follow: assert property ($past(resetn_i) |-> status_byte_two_o[3:0] ==
    $past({lockdown_allowed_i, buf_two_prog_suspended_i, buf_one_prog_suspended_i, erase_suspended_i}))
    else $error("status flags do not follow inputs");
  a_fail_update: assert property (op_done_i |-> ##2 status_byte_two_o[5] == $past(op_fail_i && !op_abort_i, 2))
    else $error("fail bit not updated at operation end");
  a_fail_holds: assert property (!$past(op_done_i, 2) |-> $stable(status_byte_two_o[5]))
    else $error("fail bit changed without operation end");
  a_busy_no_standby: assert property (op_busy_i |=> !standby_o)
    else $error("standby while busy");
  a_sleep_no_standby: assert property (deep_sleep_o |-> !standby_o)
    else $error("standby while asleep");
  a_asleep_silent: assert property (deep_sleep_o |-> !so_oe_o && !cmd_valid_o)
    else $error("activity while asleep");
  a_busy_no_sleep: assert property (op_busy_i && !deep_sleep_o |=> !deep_sleep_o)
    else $error("sleep entered while busy");
  a_guard_one: assert property ($rose(buf_one_prog_suspended_i) |-> ##[0:3] buf_one_guard_o)
    else $error("buffer one guard missing");
  a_guard_two: assert property ($rose(buf_two_prog_suspended_i) |-> ##[0:3] buf_two_guard_o)
    else $error("buffer two guard missing");
  a_reset_awake: assert property ($rose(resetn_i) |-> !deep_sleep_o)
    else $error("asleep after reset");
endmodule

bind fsd_top fsd_top_properties #(.ENTRY_NS(ENTRY_NS), .EXIT_NS(EXIT_NS)) u_props (.sys_clk_i, .resetn_i,
  .op_busy_i, .op_done_i, .op_fail_i, .op_abort_i, .lockdown_allowed_i, .buf_two_prog_suspended_i,
  .buf_one_prog_suspended_i, .erase_suspended_i, .so_oe_o, .status_byte_two_o, .standby_o, .deep_sleep_o,
  .cmd_valid_o, .buf_one_guard_o, .buf_two_guard_o);

// ### dv/fsd_host.sv
// Host controller model driving the serial link
`timescale 1ns/1ps
module fsd_host (
  // Link pins
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  logic oe_seen;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    oe_seen = 1'b0;
  end
  always @(posedge so_oe_i) oe_seen = 1'b1;
  // Frame of n bits, MSB first, SO taken on each SCK rise
  task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    cs_n_o = 1'b0;
    #62.5;
    for (int i = n - 1; i >= 0; i--) begin
      si_o = tx[i];
      #62.5 sck_o = 1'b1;
      rx[i] = so_i;
      #62.5 sck_o = 1'b0;
    end
    #62.5 cs_n_o = 1'b1;
    // Released line shows no stale level
    si_o = ~si_o;
    #200;
  endtask
endmodule

// ### dv/fsd_top_tb_top.sv
// Self-checking bench for the status and deep sleep block
`timescale 1ns/1ps
`include "fsd_consts.svh"
module fsd_top_tb_top;
  import fsd_pkg::*;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, cs_n_i, sck_i, si_i, so_o, so_oe_o;
  logic op_busy_i = 1'b0, op_done_i = 1'b0, op_fail_i = 1'b0, op_abort_i = 1'b0;
  logic cmp_done_i = 1'b0, cmp_mismatch_i = 1'b0, lockdown_allowed_i = 1'b0, protect_i = 1'b0;
  logic buf_two_prog_suspended_i = 1'b0, buf_one_prog_suspended_i = 1'b0, erase_suspended_i = 1'b0;
  logic page_512_i = 1'b0, standby_o, deep_sleep_o, cmd_valid_o, buf_one_guard_o, buf_two_guard_o;
  fsd_byte_t status_byte_two_o, cmd_opcode_o;
  int mismatches = 0;
  int samples_checked = 0;
  logic [63:0] rx;
  int cmd_seen = 0;

  initial forever #4 sys_clk_i = ~sys_clk_i;
  always @(negedge sys_clk_i) if (cmd_valid_o === 1'b1) cmd_seen++;

  fsd_top #(.ENTRY_NS(80), .EXIT_NS(80)) u_dut (.sys_clk_i, .resetn_i, .cs_n_i, .sck_i, .si_i, .so_o,
    .so_oe_o, .op_busy_i, .op_done_i, .op_fail_i, .op_abort_i, .cmp_done_i, .cmp_mismatch_i,
    .lockdown_allowed_i, .buf_two_prog_suspended_i, .buf_one_prog_suspended_i, .erase_suspended_i,
    .protect_i, .page_512_i, .status_byte_two_o, .standby_o, .deep_sleep_o, .cmd_valid_o, .cmd_opcode_o,
    .buf_one_guard_o, .buf_two_guard_o);
  fsd_host u_host (.cs_n_o(cs_n_i), .sck_o(sck_i), .si_o(si_i), .so_i(so_o), .so_oe_i(so_oe_o));

  // ==========================================
  // Shared helpers
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk("standby", 1, standby_o);
    chk("asleep", 0, deep_sleep_o);
    chk("status two", 8'h80, status_byte_two_o);
  endtask
  task automatic t_status(input logic [6:0] v);
    logic [7:0] b1, b2;
    {lockdown_allowed_i, buf_two_prog_suspended_i, buf_one_prog_suspended_i, erase_suspended_i} = v[6:3];
    {protect_i, page_512_i, cmp_mismatch_i, cmp_done_i} = {v[2:0], 1'b1};
    tick(1);
    cmp_done_i = 1'b0;
    tick(3);
    b1 = {1'b1, v[0], `FSD_CAP_CODE, v[2], v[1]};
    b2 = {4'h8, v[6:3]};
    chk("status two", b2, status_byte_two_o);
    chk("guards", {v[4], v[5]}, {buf_one_guard_o, buf_two_guard_o});
    u_host.frame({`FSD_OP_STATUS, 32'h0}, 40, rx);
    chk("status stream", {b1, b2, b1, b2}, rx[31:0]);
  endtask
  task automatic t_busy();
    op_busy_i = 1'b1;
    tick(2);
    u_host.frame(`FSD_OP_SLEEP, 8, rx);
    tick(40);
    chk("asleep busy", 0, deep_sleep_o);
    u_host.frame({`FSD_OP_STATUS, 16'h0}, 24, rx);
    chk("ready busy", 0, {rx[15], rx[7]});
    tick(1);
    op_busy_i = 1'b0;
    for (int i = 0; i < 4 && rx[7] !== 1'b1; i++) u_host.frame({`FSD_OP_STATUS, 16'h0}, 24, rx);
    chk("ready idle", 2'b11, {rx[15], rx[7]});
  endtask
  task automatic t_fail();
    logic [2:0] tbl [4] = '{3'b101, 3'b000, 3'b101, 3'b110};
    for (int i = 0; i < 4; i++) begin
      {op_fail_i, op_abort_i, op_done_i} = {tbl[i][2:1], 1'b1};
      tick(1);
      {op_fail_i, op_done_i} = 2'b10;
      tick(3);
      chk("fail bit", tbl[i][0], status_byte_two_o[5]);
    end
  endtask
  task automatic t_cmd();
    int n0;
    n0 = cmd_seen;
    u_host.frame({8'h3c, 16'h1234}, 24, rx);
    chk("cmd count", n0 + 1, cmd_seen);
    chk("cmd opcode", 8'h3c, cmd_opcode_o);
  endtask
  task automatic t_sleep();
    int n0;
    u_host.frame(`FSD_OP_SLEEP >> 1, 7, rx);
    u_host.frame({`FSD_OP_SLEEP, 4'h0}, 12, rx);
    tick(40);
    chk("short sleep", 2'b01, {deep_sleep_o, standby_o});
    u_host.frame({`FSD_OP_SLEEP, 8'h5a}, 16, rx);
    for (int i = 0; i < 40 && deep_sleep_o !== 1'b1; i++) tick(1);
    chk("asleep", 2'b10, {deep_sleep_o, standby_o});
    u_host.frame({`FSD_OP_STATUS, 16'h0}, 24, rx);
    chk("asleep output", 0, u_host.oe_seen);
    n0 = cmd_seen;
    u_host.frame(8'h3c, 8, rx);
    chk("asleep cmd", n0, cmd_seen);
    u_host.frame(`FSD_OP_WAKE >> 4, 4, rx);
    u_host.frame({`FSD_OP_WAKE, 4'h0}, 12, rx);
    tick(40);
    chk("short wake", 1, deep_sleep_o);
    u_host.frame(`FSD_OP_WAKE, 8, rx);
    for (int i = 0; i < 40 && standby_o !== 1'b1; i++) tick(1);
    chk("awake", 2'b01, {deep_sleep_o, standby_o});
    u_host.frame({`FSD_OP_STATUS, 16'h0}, 24, rx);
    chk("awake output", 1, u_host.oe_seen);
  endtask

  initial begin
    #400000;
    mismatches++;
    $display("Error watchdog expected done seen timeout");
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge sys_clk_i);
    #1 resetn_i = 1'b1;
    tick(4);
    t_reset();
    t_status(7'b1010101);
    t_status(7'b0101010);
    t_busy();
    t_cmd();
    t_fail();
    t_sleep();
    end_of_test();
  end
endmodule
